// >>> include/qcp_pkg.sv
// shared constants and types for the quadrature clock pipeline
package qcp_pkg;

    // =====================================================================
    // widths
    localparam int PC_W        = 13;
    localparam int WORD_W      = 14;
    localparam int PHASE_COUNT = 4;

    // =====================================================================
    // phase one-hot positions
    localparam int PH_ONE_BIT   = 0;
    localparam int PH_TWO_BIT   = 1;
    localparam int PH_THREE_BIT = 2;
    localparam int PH_FOUR_BIT  = 3;

    // =====================================================================
    // reset values and program counter step
    localparam logic [PHASE_COUNT-1:0] PHASE_RST = 4'h1;
    localparam logic [PC_W-1:0]        PC_RST    = 13'h0000;
    localparam logic [WORD_W-1:0]      WORD_RST  = 14'h0000;
    localparam logic [PC_W-1:0]        PC_STEP   = 13'h0001;
    localparam logic                   VALID_RST   = 1'h0;
    localparam logic                   STROBE_RST  = 1'h0;
    localparam logic                   QUARTER_RST = 1'h0;

    // =====================================================================
    // types
    typedef logic [PHASE_COUNT-1:0] qcp_phase_t;

    typedef struct packed {
        logic rd;
        logic wr;
    } qcp_dmem_t;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] word;
    } qcp_instr_t;

endpackage

// >>> design/qcp_core.sv
// phase generator and two-stage fetch/execute sequencer
// Behaviour
// - the input clock is divided by four into four non-overlapping phases forming one cycle.
// - the program counter advances once per cycle in phase one, starting each fetch.
// - the word at the fetch address is captured in phase four of the fetch cycle.
// - the captured word is presented in phase one and executed over phases two to four.
// - fetch of the next word overlaps execution, giving one instruction per cycle.
// - a taken branch discards the prefetched word and refetches, costing two cycles.
// - data memory is read in phase two and written in phase four of execution.
// - in rc mode the quarter clock output runs at one quarter of the input clock rate.
`timescale 1ns/1ps
module qcp_core (
    input  wire logic                       ref_clk_in,
    input  wire logic                       arst_n_in,
    input  wire logic                       rc_mode_in,
    input  wire logic [qcp_pkg::WORD_W-1:0] prog_data_in,
    input  wire logic                       dest_write_in,
    input  wire logic                       branch_in,
    input  wire logic [qcp_pkg::PC_W-1:0]   branch_target_in,
    output qcp_pkg::qcp_phase_t             phase_out,
    output logic      [qcp_pkg::PC_W-1:0]   prog_addr_out,
    output qcp_pkg::qcp_instr_t             instr_out,
    output qcp_pkg::qcp_dmem_t              dmem_out,
    output logic                            quarter_clock_out
);

    // =====================================================================
    // registers
    qcp_pkg::qcp_phase_t          phase_reg;
    logic [qcp_pkg::PC_W-1:0]     pc_reg;
    logic [qcp_pkg::PC_W-1:0]     fetch_addr_reg;
    logic [qcp_pkg::WORD_W-1:0]   word_reg;
    logic                         valid_reg;
    logic                         rd_reg;
    logic                         wr_reg;
    logic                         quarter_reg;

    // =====================================================================
    // next values
    qcp_pkg::qcp_phase_t          phase_next;
    logic [qcp_pkg::PC_W-1:0]     pc_next;
    logic [qcp_pkg::PC_W-1:0]     fetch_addr_next;
    logic [qcp_pkg::WORD_W-1:0]   word_next;
    logic                         valid_next;
    logic                         rd_next;
    logic                         wr_next;
    logic                         quarter_next;

    // =====================================================================
    // phase decode and branch decision
    logic                         in_one;
    logic                         in_three;
    logic                         in_four;
    logic                         take_branch;

    // phase two needs no decode: the read strobe is launched from phase one
    assign in_one   = phase_reg[qcp_pkg::PH_ONE_BIT];
    assign in_three = phase_reg[qcp_pkg::PH_THREE_BIT];
    assign in_four  = phase_reg[qcp_pkg::PH_FOUR_BIT];

    // taken at the close of phase four, once the decoder has settled; a bubble
    // in execution never redirects the fetch
    assign take_branch = in_four && valid_reg && branch_in;

    // =====================================================================
    // phase generator
    // a rotating one-hot keeps the phases non-overlapping by construction,
    // where a binary count with a decoder could briefly show two phases
    always_comb begin
        phase_next = {phase_reg[qcp_pkg::PHASE_COUNT-2:0],
                      phase_reg[qcp_pkg::PHASE_COUNT-1]};
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_reg <= qcp_pkg::PHASE_RST;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // =====================================================================
    // program counter
    // a branch target overrides the step; the two never share a phase anyway
    always_comb begin
        pc_next = pc_reg;
        if (take_branch) begin
            pc_next = branch_target_in;
        end else if (in_one) begin
            pc_next = pc_reg + qcp_pkg::PC_STEP;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pc_reg <= qcp_pkg::PC_RST;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // =====================================================================
    // fetch address
    // latches the pre-increment count, so the fetch after reset reads address
    // zero and the address stands unchanged for the whole fetch cycle
    always_comb begin
        fetch_addr_next = fetch_addr_reg;
        if (in_one) begin
            fetch_addr_next = pc_reg;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fetch_addr_reg <= qcp_pkg::PC_RST;
        end else begin
            fetch_addr_reg <= fetch_addr_next;
        end
    end

    // =====================================================================
    // instruction word
    always_comb begin
        word_next = word_reg;
        if (in_four) begin
            // capture and hand over on one edge: visible from phase one
            word_next = prog_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            word_reg <= qcp_pkg::WORD_RST;
        end else begin
            word_reg <= word_next;
        end
    end

    // =====================================================================
    // instruction valid
    // the word fetched alongside a taken branch is stale and becomes a bubble;
    // reset clears it so that the first cycle only fetches
    always_comb begin
        valid_next = valid_reg;
        if (in_four) begin
            valid_next = !take_branch;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            valid_reg <= qcp_pkg::VALID_RST;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // =====================================================================
    // data memory read strobe
    // launched one phase ahead so that the strobe leaves a flip-flop
    always_comb begin
        rd_next = 1'h0;
        if (in_one && valid_reg) begin
            rd_next = 1'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_reg <= qcp_pkg::STROBE_RST;
        end else begin
            rd_reg <= rd_next;
        end
    end

    // =====================================================================
    // data memory write strobe
    // the write request is taken late, giving the decoder three phases to settle
    always_comb begin
        wr_next = 1'h0;
        if (in_three && valid_reg && dest_write_in) begin
            wr_next = 1'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_reg <= qcp_pkg::STROBE_RST;
        end else begin
            wr_reg <= wr_next;
        end
    end

    // =====================================================================
    // quarter clock
    // high across phases one and two, low across three and four; held low
    // outside rc mode, where the pin belongs to the crystal
    always_comb begin
        quarter_next = 1'h0;
        if (rc_mode_in && (in_four || in_one)) begin
            quarter_next = 1'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            quarter_reg <= qcp_pkg::QUARTER_RST;
        end else begin
            quarter_reg <= quarter_next;
        end
    end

    // =====================================================================
    // outputs
    // every output is a plain copy of a register, so none can glitch
    assign phase_out         = phase_reg;
    assign prog_addr_out     = fetch_addr_reg;
    assign instr_out         = {valid_reg, word_reg};
    assign dmem_out          = {rd_reg, wr_reg};
    assign quarter_clock_out = quarter_reg;

endmodule // qcp_core

// >>> verification/qcp_osc_model.sv
// oscillator model that drives the core's input clock
`timescale 1ns/1ps
module qcp_osc_model (
    output logic clk_out
);
    initial begin
        clk_out = 1'b0;
        forever #2.5 clk_out = ~clk_out;
    end
endmodule // qcp_osc_model

// >>> verification/qcp_core_chk.sv
// port assertions for the quadrature clock pipeline core
`timescale 1ns/1ps
module qcp_core_chk (
    input wire logic                [12:0] branch_target_in, prog_addr_out,
    input wire logic                [13:0] prog_data_in,
    input wire logic                ref_clk_in, arst_n_in, rc_mode_in, dest_write_in, branch_in,
    input wire qcp_pkg::qcp_phase_t phase_out,
    input wire qcp_pkg::qcp_instr_t instr_out,
    input wire qcp_pkg::qcp_dmem_t  dmem_out,
    input wire logic                quarter_clock_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    wire [3:0] ph = phase_out;
    wire       v  = instr_out.valid;
    wire       br = ph[3] && branch_in && v;
    a_phase_onehot: assert property ($onehot(ph)) else $error("phase not one-hot");
    a_phase_order: assert property (ph[0] |=> ph[1] ##1 ph[2] ##1 ph[3] ##1 ph[0])
        else $error("phase order");
    a_addr_hold: assert property ($changed(prog_addr_out) |-> ph[1]) else $error("addr");
    a_seq_fetch: assert property (ph[3] && !br |=>
        v && instr_out.word == $past(prog_data_in)
        ##1 prog_addr_out == $past(prog_addr_out, 2) + 13'h0001) else $error("fetch");
    a_branch_flush: assert property (br |=> !v ##1 prog_addr_out == $past(branch_target_in, 2))
        else $error("branch");
    a_read_slot: assert property (dmem_out.rd == (ph[1] && v)) else $error("read slot");
    a_write_slot: assert property (dmem_out.wr == (ph[3] && v && $past(dest_write_in)))
        else $error("write slot");
    a_quarter_rate: assert property (quarter_clock_out ==
        ($past(rc_mode_in) && $past(arst_n_in) && (ph[0] || ph[1])))
        else $error("quarter clock");
    c_branch: cover property (br);
    c_write: cover property (dmem_out.wr);
    c_quarter: cover property (quarter_clock_out);
endmodule // qcp_core_chk
bind qcp_core qcp_core_chk u_chk (
    .branch_target_in  (branch_target_in),
    .prog_addr_out     (prog_addr_out),
    .prog_data_in      (prog_data_in),
    .ref_clk_in        (ref_clk_in),
    .arst_n_in         (arst_n_in),
    .rc_mode_in        (rc_mode_in),
    .dest_write_in     (dest_write_in),
    .branch_in         (branch_in),
    .phase_out         (phase_out),
    .instr_out         (instr_out),
    .dmem_out          (dmem_out),
    .quarter_clock_out (quarter_clock_out)
);

// >>> verification/test_quadrature_clock_pipeline.sv
// self-checking bench for the quadrature clock pipeline core
`timescale 1ns/1ps
module test_quadrature_clock_pipeline;
    logic                ref_clk_in, arst_n_in, rc_mode_in, dest_write_in, branch_in;
    logic [13:0]         prog_data_in;
    logic [12:0]         branch_target_in, prog_addr_out, ea;
    qcp_pkg::qcp_phase_t phase_out;
    qcp_pkg::qcp_instr_t instr_out;
    qcp_pkg::qcp_dmem_t  dmem_out;
    logic                quarter_clock_out;
    int                  n_errors = 0, checks_done = 0;
    qcp_osc_model osc (.clk_out(ref_clk_in));
    qcp_core dut (
        .ref_clk_in        (ref_clk_in),
        .arst_n_in         (arst_n_in),
        .rc_mode_in        (rc_mode_in),
        .prog_data_in      (prog_data_in),
        .dest_write_in     (dest_write_in),
        .branch_in         (branch_in),
        .branch_target_in  (branch_target_in),
        .phase_out         (phase_out),
        .prog_addr_out     (prog_addr_out),
        .instr_out         (instr_out),
        .dmem_out          (dmem_out),
        .quarter_clock_out (quarter_clock_out)
    );
    // program memory: word is its address plus 0x100
    always @(negedge ref_clk_in) prog_data_in <= {1'b0, prog_addr_out} + 14'h0100;
    task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_ph(input logic [3:0] p);
        for (int i = 0; i < 9 && phase_out !== p; i++) @(negedge ref_clk_in);
        if (phase_out !== p) begin
            n_errors++;
            $display("[FAIL] phase wait exp %h got %h", p, phase_out);
            final_report();
        end
    endtask
    task automatic t_reset;
        arst_n_in = 1'b0;
        repeat (16) @(negedge ref_clk_in);
        chk("phase", 15'h0001, {11'h0, phase_out});
        chk("instr", 15'h0000, instr_out);
        chk("dmem", 15'h0000, {13'h0, dmem_out});
        arst_n_in = 1'b1;
        @(negedge ref_clk_in);
        chk("phase", 15'h0002, {11'h0, phase_out});
        chk("addr", 15'h0000, {2'h0, prog_addr_out});
        chk("rd", 15'h0000, {14'h0, dmem_out.rd});
        chk("quarter", {14'h0, rc_mode_in}, {14'h0, quarter_clock_out});
    endtask
    task automatic t_run(input int n);
        repeat (n) begin
            wait_ph(4'h8);
            ea = prog_addr_out;
            @(negedge ref_clk_in);
            chk("instr", {2'h2, ea + 13'h0100}, instr_out);
            wait_ph(4'h2);
            chk("addr", {2'h0, ea + 13'h0001}, {2'h0, prog_addr_out});
            chk("rd", 15'h0001, {14'h0, dmem_out.rd});
            chk("quarter", {14'h0, rc_mode_in}, {14'h0, quarter_clock_out});
            wait_ph(4'h8);
            chk("wr", {14'h0, dest_write_in}, {14'h0, dmem_out.wr});
        end
    endtask
    task automatic t_branch;
        wait_ph(4'h8);
        branch_in = 1'b1;
        branch_target_in = 13'h0abc;
        @(negedge ref_clk_in);
        branch_in = 1'b0;
        chk("valid", 15'h0000, {14'h0, instr_out.valid});
        wait_ph(4'h2);
        chk("addr", 15'h0abc, {2'h0, prog_addr_out});
        chk("rd", 15'h0000, {14'h0, dmem_out.rd});
        t_run(2);
    endtask
    initial begin
        {rc_mode_in, branch_in, dest_write_in} = 3'h1;
        branch_target_in = 13'h0000;
        t_reset();
        t_run(3);
        {rc_mode_in, dest_write_in} = 2'h2;
        t_branch();
        t_reset();
        final_report();
    end
endmodule // test_quadrature_clock_pipeline
